// File: src/acmp_pkg.sv
// Package: register map, field positions, reset values and carrier types of the comparator control block
package acmp_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;

  // Control register field positions
  localparam int ENABLE_BIT = 15;
  localparam int OUT_PIN_EN_BIT = 14;
  localparam int INVERT_BIT = 13;
  localparam int RESULT_BIT = 8;
  localparam int EDGE_SEL_HI = 7;
  localparam int EDGE_SEL_LO = 6;
  localparam int POS_SEL_BIT = 4;
  localparam int NEG_SEL_HI = 1;
  localparam int NEG_SEL_LO = 0;

  // Writable bits of the control register
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_E0D3;

  // Reset values of the writable fields
  localparam logic CTRL_ENABLE_RST = 1'b0;
  localparam logic CTRL_OUT_PIN_EN_RST = 1'b0;
  localparam logic CTRL_INVERT_RST = 1'b0;
  localparam logic [1:0] CTRL_EDGE_SEL_RST = 2'b11;
  localparam logic CTRL_POS_SEL_RST = 1'b0;
  localparam logic [1:0] CTRL_NEG_SEL_RST = 2'b11;
  localparam logic [1:0] MASK_RST = 2'b00;

  // Event edge selection codes
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  // Negative input routing codes
  typedef enum logic [1:0] {
    NEG_PIN_B = 2'b00,
    NEG_PIN_C = 2'b01,
    NEG_PIN_D = 2'b10,
    NEG_PRECISION = 2'b11
  } neg_sel_t;

  // Status bit positions: bit 0 edge event, bit 1 enable-drop event
  localparam int STAT_EDGE_BIT = 0;
  localparam int STAT_OFF_BIT = 1;

  // Control fields carried together
  typedef struct packed {
    logic enable;
    logic out_pin_en;
    logic invert;
    edge_sel_t edge_sel;
    logic pos_sel;
    neg_sel_t neg_sel;
  } ctrl_t;

  // Signals sent to the analog core
  typedef struct packed {
    logic enable;
    logic pos_sel;
    neg_sel_t neg_sel;
  } analog_cfg_t;

  // Control reset value as one constant
  localparam ctrl_t CTRL_RST = '{enable: CTRL_ENABLE_RST, out_pin_en: CTRL_OUT_PIN_EN_RST,
    invert: CTRL_INVERT_RST, edge_sel: edge_sel_t'(CTRL_EDGE_SEL_RST), pos_sel: CTRL_POS_SEL_RST,
    neg_sel: neg_sel_t'(CTRL_NEG_SEL_RST)};

endpackage

// File: src/acmp_sync.sv
// Two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module acmp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg; // First stage, read only by the second
  logic sync_reg; // Second stage
  logic meta_next;
  logic sync_next;

  // Next values
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // Register both stages
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule

// File: src/acmp_edge.sv
// Edge detector that turns the polarity-adjusted result into one event pulse
`timescale 1ns/1ps
module acmp_edge (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  input wire acmp_pkg::edge_sel_t i_edge_sel,
  output logic o_event
);
  import acmp_pkg::*;

  logic prev_reg; // Level seen last cycle
  logic prev_next;
  logic rise;
  logic fall;

  // Next value and edge decode
  always_comb begin
    prev_next = i_level;
    rise = i_level & ~prev_reg;
    fall = ~i_level & prev_reg;
    unique case (i_edge_sel)
      EDGE_NONE: o_event = 1'b0;
      EDGE_RISE: o_event = rise;
      EDGE_FALL: o_event = fall;
      EDGE_BOTH: o_event = rise | fall;
    endcase
  end

  // Register last level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end
endmodule

// File: src/acmp_ctrl.sv
// Comparator control block: APB registers, pin drive, polarity, event and interrupt logic
`timescale 1ns/1ps

//
// Operation
// - Enable set turns comparator on, others kept
// - Enable clear turns comparator off, others kept
// - Output enable drives result onto pin while comparator is on
// - Invert bit flips comparator output
// - Inversion also feeds the event generator
// - Status bit shows current result, resets zero
// - Edge select: both, falling, rising, or none
// - Positive select: reference or pin A
// - Negative select: precision ref, D, C, B
// - Unimplemented bits read zero, ignore writes
module acmp_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Analog core
  input wire logic i_raw_result,
  output acmp_pkg::analog_cfg_t o_analog_cfg,
  // Output pin data and enable; enable active low
  output logic o_result_pin_out,
  output logic o_result_pin_oe_n,
  // Interrupt
  output logic o_irq
);
  import acmp_pkg::*;

  ctrl_t ctrl_reg; // Control fields
  ctrl_t ctrl_next;
  logic [1:0] stat_reg; // Sticky events
  logic [1:0] stat_next;
  logic [1:0] mask_reg; // Interrupt mask
  logic [1:0] mask_next;
  logic [31:0] rdata_reg; // Read data
  logic [31:0] rdata_next;
  logic pin_reg; // Pin output data
  logic pin_next;
  logic oe_n_reg; // Pin enable, low drives
  logic oe_n_next;
  logic result_sync; // Synchronised raw result
  logic result_pol; // Result after polarity
  logic edge_event; // One-cycle edge pulse
  logic access; // APB access phase
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic addr_ok;

  // Pack the control register into its bus word
  function automatic logic [31:0] ctrl_word(input ctrl_t c, input logic res);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ENABLE_BIT] = c.enable;
    w[OUT_PIN_EN_BIT] = c.out_pin_en;
    w[INVERT_BIT] = c.invert;
    w[RESULT_BIT] = res;
    w[EDGE_SEL_HI:EDGE_SEL_LO] = c.edge_sel;
    w[POS_SEL_BIT] = c.pos_sel;
    w[NEG_SEL_HI:NEG_SEL_LO] = c.neg_sel;
    return w;
  endfunction

  // Synchronise the asynchronous result
  acmp_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_raw_result),
    .o_sync(result_sync)
  );

  // Polarity; a disabled comparator reads as 0
  assign result_pol = ctrl_reg.enable & (result_sync ^ ctrl_reg.invert);

  // Edge detection on the polarity-adjusted level
  acmp_edge u_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(result_pol),
    .i_edge_sel(ctrl_reg.edge_sel),
    .o_event(edge_event)
  );

  // Bus decode; always ready, no wait states
  always_comb begin
    access = i_psel & i_penable;
    addr_ok = (i_paddr == CTRL_OFFSET) | (i_paddr == STATUS_OFFSET) | (i_paddr == MASK_OFFSET);
    wr_ctrl = access & i_pwrite & (i_paddr == CTRL_OFFSET);
    wr_mask = access & i_pwrite & (i_paddr == MASK_OFFSET);
    rd_stat = access & ~i_pwrite & (i_paddr == STATUS_OFFSET);
  end

  assign o_pready = 1'b1;
  assign o_pslverr = access & ~addr_ok;

  // Register next values
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    rdata_next = rdata_reg;
    // Control write touches only writable fields
    if (wr_ctrl) begin
      ctrl_next.enable = i_pwdata[ENABLE_BIT];
      ctrl_next.out_pin_en = i_pwdata[OUT_PIN_EN_BIT];
      ctrl_next.invert = i_pwdata[INVERT_BIT];
      ctrl_next.edge_sel = edge_sel_t'(i_pwdata[EDGE_SEL_HI:EDGE_SEL_LO]);
      ctrl_next.pos_sel = i_pwdata[POS_SEL_BIT];
      ctrl_next.neg_sel = neg_sel_t'(i_pwdata[NEG_SEL_HI:NEG_SEL_LO]);
    end
    // Mask write
    if (wr_mask) begin
      mask_next = i_pwdata[1:0];
    end
    // Read of status clears only the bits it reported; a new event in the same cycle wins
    // An event that lands after the setup capture stays for the next read
    if (rd_stat) begin
      stat_next = stat_reg & ~rdata_reg[1:0];
    end
    if (edge_event) begin
      stat_next[STAT_EDGE_BIT] = 1'b1;
    end
    if (wr_ctrl & ctrl_reg.enable & ~i_pwdata[ENABLE_BIT]) begin
      stat_next[STAT_OFF_BIT] = 1'b1;
    end
    // Read data captured in setup phase, presented in access phase
    if (i_psel & ~i_penable & ~i_pwrite) begin
      unique case (i_paddr)
        CTRL_OFFSET: rdata_next = ctrl_word(ctrl_reg, result_pol);
        STATUS_OFFSET: rdata_next = {30'h0000_0000, stat_reg};
        MASK_OFFSET: rdata_next = {30'h0000_0000, mask_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register updates
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
      stat_reg <= 2'b00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
    end
  end

  // Read data from the flop loaded in the setup cycle
  assign o_prdata = rdata_reg;

  // Pin drive: data and enable registered
  always_comb begin
    pin_next = result_pol & ctrl_reg.out_pin_en;
    oe_n_next = ~(ctrl_reg.out_pin_en & ctrl_reg.enable);
  end

  // Register pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign o_result_pin_out = pin_reg;
  assign o_result_pin_oe_n = oe_n_reg;

  // Analog configuration straight from control flops
  assign o_analog_cfg.enable = ctrl_reg.enable;
  assign o_analog_cfg.pos_sel = ctrl_reg.pos_sel;
  assign o_analog_cfg.neg_sel = ctrl_reg.neg_sel;

  // Level interrupt from unmasked sticky bits
  assign o_irq = |(stat_reg & mask_reg);

  // Assertions
  property p_enable_write;
    @(posedge i_clk) disable iff (i_rst)
    wr_ctrl |=> (o_analog_cfg.enable == $past(i_pwdata[ENABLE_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not taken");

  property p_disable_keeps;
    @(posedge i_clk) disable iff (i_rst)
    (wr_ctrl && !i_pwdata[ENABLE_BIT]) |=> (!o_analog_cfg.enable && ctrl_reg.invert == $past(i_pwdata[INVERT_BIT]));
  endproperty
  a_disable_keeps: assert property (p_disable_keeps) else $error("disable wrong");

  property p_pin_drive;
    @(posedge i_clk) disable iff (i_rst)
    (ctrl_reg.out_pin_en && ctrl_reg.enable) |=> (!o_result_pin_oe_n && o_result_pin_out == $past(result_pol));
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");

  property p_pin_off;
    @(posedge i_clk) disable iff (i_rst)
    !ctrl_reg.out_pin_en |=> (o_result_pin_oe_n && !o_result_pin_out);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven when off");

  property p_invert;
    @(posedge i_clk) disable iff (i_rst)
    ctrl_reg.enable |-> (result_pol == ($past(i_raw_result, 2) ^ ctrl_reg.invert));
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_rise_event;
    @(posedge i_clk) disable iff (i_rst)
    (ctrl_reg.edge_sel == EDGE_RISE && $stable(ctrl_reg.edge_sel) && $rose(result_pol)) |=> stat_reg[STAT_EDGE_BIT];
  endproperty
  a_rise_event: assert property (p_rise_event) else $error("rise lost");

  property p_no_event;
    @(posedge i_clk) disable iff (i_rst)
    (ctrl_reg.edge_sel == EDGE_NONE) |-> !edge_event;
  endproperty
  a_no_event: assert property (p_no_event) else $error("event while disabled");

  property p_fall_only;
    @(posedge i_clk) disable iff (i_rst)
    (ctrl_reg.edge_sel == EDGE_FALL && edge_event) |-> ($past(result_pol) && !result_pol);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("wrong edge");

  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_rst)
    (access && !i_pwrite && i_paddr == CTRL_OFFSET) |-> ((o_prdata & ~CTRL_WRITE_MASK & ~32'h0000_0100) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_sync_delay;
    @(posedge i_clk) disable iff (i_rst)
    $rose(i_raw_result) ##1 i_raw_result ##1 i_raw_result |-> result_sync;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

  property p_status_result;
    @(posedge i_clk) disable iff (i_rst)
    (i_psel && !i_penable && !i_pwrite && i_paddr == CTRL_OFFSET) |=> (o_prdata[RESULT_BIT] == $past(result_pol));
  endproperty
  a_status_result: assert property (p_status_result) else $error("result bit wrong");

  // Event flag, disable flag, field, pin and routing checks
  property p_event_sets;
    @(posedge i_clk) disable iff (i_rst)
    edge_event |=> stat_reg[STAT_EDGE_BIT];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event flag not set");

  property p_read_clears;
    @(posedge i_clk) disable iff (i_rst)
    (rd_stat && !edge_event && rdata_reg[STAT_EDGE_BIT]) |=> !stat_reg[STAT_EDGE_BIT];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("event flag not cleared by read");

  property p_off_event;
    @(posedge i_clk) disable iff (i_rst)
    (wr_ctrl && ctrl_reg.enable && !i_pwdata[ENABLE_BIT]) |=> stat_reg[STAT_OFF_BIT];
  endproperty
  a_off_event: assert property (p_off_event) else $error("disable flag not set");

  property p_write_fields;
    @(posedge i_clk) disable iff (i_rst)
    wr_ctrl |=> (ctrl_word(ctrl_reg, 1'b0) == ($past(i_pwdata) & CTRL_WRITE_MASK));
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("reserved bits stored");

  property p_off_pin;
    @(posedge i_clk) disable iff (i_rst)
    !ctrl_reg.enable |=> o_result_pin_oe_n;
  endproperty
  a_off_pin: assert property (p_off_pin) else $error("pin driven while off");

  property p_route;
    @(posedge i_clk) disable iff (i_rst)
    wr_ctrl |=> (o_analog_cfg.neg_sel == $past(i_pwdata[NEG_SEL_HI:NEG_SEL_LO]) &&
      o_analog_cfg.pos_sel == $past(i_pwdata[POS_SEL_BIT]));
  endproperty
  a_route: assert property (p_route) else $error("input routing wrong");

  c_enable: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_analog_cfg.enable));
  c_irq: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
  c_both: cover property (@(posedge i_clk) disable iff (i_rst) edge_event && ctrl_reg.edge_sel == EDGE_BOTH);
  c_race: cover property (@(posedge i_clk) disable iff (i_rst) rd_stat && edge_event);
endmodule

// File: tb/acmp_core_model.sv
// Behavioural model of the analog comparator core and its input multiplexers
`timescale 1ns/1ps
module acmp_core_model #(
  parameter logic [7:0] REF_LEVEL = 8'h50,
  parameter logic [7:0] PREC_LEVEL = 8'hA0
) (
  input wire acmp_pkg::analog_cfg_t i_cfg,
  input wire logic [7:0] i_pin_a,
  input wire logic [7:0] i_pin_b,
  input wire logic [7:0] i_pin_c,
  input wire logic [7:0] i_pin_d,
  output logic o_raw
);
  import acmp_pkg::*;
  logic [7:0] pos_lvl; // Level on the non-inverting input
  logic [7:0] neg_lvl; // Level on the inverting input
  // Input multiplexers
  always_comb begin
    pos_lvl = i_cfg.pos_sel ? REF_LEVEL : i_pin_a;
    case (i_cfg.neg_sel)
      NEG_PIN_B: neg_lvl = i_pin_b;
      NEG_PIN_C: neg_lvl = i_pin_c;
      NEG_PIN_D: neg_lvl = i_pin_d;
      default: neg_lvl = PREC_LEVEL;
    endcase
  end
  // An unpowered core gives noise, so the block must not trust it
  assign o_raw = i_cfg.enable ? (pos_lvl > neg_lvl) : ~i_pin_a[0];
endmodule

// File: tb/acmp_ctrl_tb.sv
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
module acmp_ctrl_tb;
  import acmp_pkg::*;
  logic i_clk, i_rst, psel, pen, pwr, err, irq, raw, pin_out, pin_oe_n, rdy, slverr;
  logic [7:0] addr, pa, pb, pc, pd;
  logic [31:0] wdata, rdata, rd;
  analog_cfg_t cfg;
  int errors, check_count;
  logic [7:0] neg_lvl [4] = '{8'h10, 8'h48, 8'h78, 8'hA0}; // Pin B, C, D, precision
  acmp_ctrl dut(.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy), .o_pslverr(err),
    .i_raw_result(raw), .o_analog_cfg(cfg), .o_result_pin_out(pin_out),
    .o_result_pin_oe_n(pin_oe_n), .o_irq(irq));
  acmp_core_model #(.REF_LEVEL(8'h50), .PREC_LEVEL(8'hA0)) core(.i_cfg(cfg), .i_pin_a(pa),
    .i_pin_b(pb), .i_pin_c(pc), .i_pin_d(pd), .o_raw(raw));
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (rdy !== 1'b1) @(posedge i_clk);
    rd = rdata;
    slverr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
  endtask
  // Lets the two-flop sync and event logic settle
  task automatic settle();
    repeat (6) @(posedge i_clk);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic ev;
    i_rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    pa = 8'h00;
    pb = neg_lvl[0];
    pc = neg_lvl[1];
    pd = neg_lvl[2];
    errors = 0;
    check_count = 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk("ctrl reset", CTRL_OFFSET, 32'h0000_00C3);
    check("irq reset", irq, 32'h0000_0000);
    // All ones: reserved bits drop, inverted low result reads one
    apb(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
    settle();
    rd_chk("ctrl all ones", CTRL_OFFSET, 32'h0000_E1D3);
    check("cfg all ones", cfg, 32'h0000_000F);
    check("pin drive", {pin_oe_n, pin_out}, 32'h0000_0001);
    apb(1'b1, CTRL_OFFSET, 32'h0000_60D3);
    settle();
    rd_chk("ctrl off", CTRL_OFFSET, 32'h0000_60D3);
    check("cfg off", cfg, 32'h0000_0007);
    check("pin released", {pin_oe_n, pin_out}, 32'h0000_0002);
    apb(1'b1, CTRL_OFFSET, 32'h0000_80D3);
    settle();
    rd_chk("ctrl on", CTRL_OFFSET, 32'h0000_80D3);
    rd_chk("unmapped read", 8'h0C, 32'h0000_0000);
    check("unmapped error", slverr, 32'h0000_0001);
    // Every edge code, with and without inversion
    apb(1'b1, MASK_OFFSET, 32'h0000_0001);
    for (int inv = 0; inv < 2; inv++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, CTRL_OFFSET, {16'h0000, 2'b10, inv[0], 5'h00, c[1:0], 6'h00});
        settle();
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        pa <= 8'hF0;
        settle();
        ev = inv[0] ? c[1] : c[0];
        check("irq on rise", irq, {31'h0, ev});
        rd_chk("status rise", STATUS_OFFSET, {31'h0, ev});
        @(posedge i_clk);
        check("irq cleared", irq, 32'h0000_0000);
        pa <= 8'h00;
        settle();
        ev = inv[0] ? c[0] : c[1];
        rd_chk("status fall", STATUS_OFFSET, {31'h0, ev});
      end
    end
    // Input routing, edge code none; pin A moves only once events are off
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 4; n++) begin
        apb(1'b1, CTRL_OFFSET, {16'h0000, 8'h80, 3'b000, p[0], 2'b00, n[1:0]});
        pa <= 8'h40;
        settle();
        check("cfg route", cfg, {28'h0, 1'b1, p[0], n[1:0]});
        rd_chk("routed result", CTRL_OFFSET, {16'h0000, 7'h40, (p[0] ? 8'h50 : 8'h40) > neg_lvl[n],
          3'b000, p[0], 2'b00, n[1:0]});
      end
    end
    rd_chk("no events", STATUS_OFFSET, 32'h0000_0000);
    // Masked edge, then unmasked disable event
    apb(1'b1, MASK_OFFSET, 32'h0000_0002);
    apb(1'b1, STATUS_OFFSET, 32'h0000_0003);
    apb(1'b1, CTRL_OFFSET, 32'h0000_80C0);
    pa <= 8'hF0;
    settle();
    check("masked irq", irq, 32'h0000_0000);
    rd_chk("status ignores write", STATUS_OFFSET, 32'h0000_0001);
    apb(1'b1, CTRL_OFFSET, 32'h0000_00C0);
    settle();
    check("irq on disable", irq, 32'h0000_0001);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    check("disable status", rd & 32'h0000_0002, 32'h0000_0002);
    end_of_test();
  end
endmodule
